// [hw/uie_top.sv]
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Interrupt enable, identification and polled line status for one channel
module uie_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Receive side status from the data path
    input wire logic [4:0] rx_count,
    input wire logic rx_char_in,
    input wire logic [3:0] rx_err_flags,
    input wire logic rx_fifo_err,
    // Transmit side status from the data path
    input wire logic tx_fifo_empty,
    input wire logic tx_shift_empty,
    // Modem change bits from the modem state register
    input wire logic [3:0] modem_change,
    // Interrupt request pin
    output logic irq_n
);
    typedef struct packed
    {
        uie_pkg::uie_bus_t bus;
        logic [3:0] mask;
        logic [7:0] fifo_control_register;
        logic data_ready;
        logic tx_empty_d;
        logic [31:0] rdata;
        logic irq_n;
        logic wreq;
    } uie_top_st_t;
    uie_top_st_t st_r;
    uie_top_st_t st_nxt;
    uie_src_if src ();
    logic [7:0] line_state;

    // Trigger level decode
    function automatic logic [4:0] uie_trig(input logic [1:0] sel);
        unique case (sel)
            2'b00: uie_trig = uie_pkg::UIE_TRIG_L0;
            2'b01: uie_trig = uie_pkg::UIE_TRIG_L1;
            2'b10: uie_trig = uie_pkg::UIE_TRIG_L2;
            2'b11: uie_trig = uie_pkg::UIE_TRIG_L3;
        endcase
    endfunction

    uie_eval u_eval
    (
        .clk(clk),
        .rst(rst),
        .s(src)
    );

    // ==========================================
    // Source wiring
    always_comb
    begin
        src.enables = st_r.mask;
        src.fifo_mode = st_r.fifo_control_register[uie_pkg::UIE_FCR_EN];
        src.trig_level = uie_trig(st_r.fifo_control_register[7:uie_pkg::UIE_FCR_TRIG_LO]);
        src.rx_count = rx_count;
        src.rx_hold_full = st_r.data_ready;
        src.modem_change = modem_change;
        src.line_err = rx_err_flags;
        src.tx_empty_evt = tx_fifo_empty && !st_r.tx_empty_d;
        src.tx_clear = (st_r.bus == uie_pkg::UIE_IDLE) && ((avs_read
            && avs_address == uie_pkg::UIE_OFS_IDENT) || !tx_fifo_empty);
    end

    // Line state image
    always_comb
    begin
        line_state = {rx_fifo_err, tx_fifo_empty && tx_shift_empty, tx_fifo_empty,
            rx_err_flags, st_r.data_ready};
    end

    // ==========================================
    // Register bus and state update
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tx_empty_d = tx_fifo_empty;
        // Data ready: entry sets, empty FIFO clears; entry wins
        if (rx_count == 5'h00)
            st_nxt.data_ready = 1'b0;
        if (rx_char_in || rx_count != 5'h00)
            st_nxt.data_ready = 1'b1;
        st_nxt.irq_n = !src.irq_any;
        unique case (st_r.bus)
            uie_pkg::UIE_IDLE:
            begin
                if (avs_write)
                begin
                    st_nxt.bus = uie_pkg::UIE_ACK;
                    if (avs_address == uie_pkg::UIE_OFS_MASK)
                        st_nxt.mask = avs_writedata[3:0];
                    else if (avs_address == uie_pkg::UIE_OFS_FIFO_CTRL)
                        st_nxt.fifo_control_register = {avs_writedata[7:6], 2'b00, avs_writedata[3:0]};
                end
                else if (avs_read)
                begin
                    st_nxt.bus = uie_pkg::UIE_ACK;
                    unique case (avs_address)
                        uie_pkg::UIE_OFS_MASK: st_nxt.rdata = {28'h0000000, st_r.mask};
                        uie_pkg::UIE_OFS_FIFO_CTRL: st_nxt.rdata = {24'h000000, st_r.fifo_control_register};
                        uie_pkg::UIE_OFS_IDENT: st_nxt.rdata = {24'h000000,
                            {2{st_r.fifo_control_register[uie_pkg::UIE_FCR_EN]}}, 2'b00, src.ident};
                        uie_pkg::UIE_OFS_LINE: st_nxt.rdata = {24'h000000, line_state};
                        default: st_nxt.rdata = 32'h00000000;
                    endcase
                end
            end
            uie_pkg::UIE_ACK:
                st_nxt.bus = uie_pkg::UIE_IDLE;
            default:
                st_nxt.bus = uie_pkg::UIE_IDLE;
        endcase
        // Waitrequest kept in its own flop so the pin comes straight from a register
        st_nxt.wreq = (st_nxt.bus != uie_pkg::UIE_ACK);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.mask <= uie_pkg::UIE_MASK_RST;
            st_r.fifo_control_register <= uie_pkg::UIE_FCR_RST;
            st_r.tx_empty_d <= 1'b1;
            st_r.irq_n <= 1'b1;
            st_r.wreq <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs from flops; waitrequest low only in the answer cycle
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.wreq;
    assign irq_n = st_r.irq_n;
endmodule

// [hw/uie_pkg.sv]
// What this block does
// - Modem status enable on: any modem change bit raises the interrupt.
// - Line status enable on: any receive error bit four..one raises interrupt.
// - Transmit enable on: interrupt on holding empty, or FIFO empty in FIFO mode.
// - Enabled transmit-empty interrupt reports as identification level three.
// - Non-FIFO, receive enable on: interrupt while holding register has data.
// - FIFO mode, receive enable on: interrupt while count at or above trigger.
// - Enabled receive-ready interrupt reports as identification level two.
// - Upper four enable bits ignore writes and read zero.
// - Identification receive status follows trigger reach, clears with the interrupt.
// - Data ready bit sets on character entry, clears when receive FIFO empties.
// - Transmit empty interrupt clears on identification read or while transmit FIFO is not empty.
// - FIFO mode with enables clear: no interrupts, host polls line status.
// - Data ready stays one while any byte remains in the receive FIFO.
// - Line status bits four..one show receive error kind or break.
// - Bit five shows transmit FIFO empty; bit six FIFO and shifter empty.
// - Bit seven shows any data error among characters in receive FIFO.
// - Enabled conditions of all four sources appear on interrupt request pin.
// - FIFO enable bit zero at one selects FIFO mode, at zero selects single-character.
// - Top two FIFO control bits choose the receive trigger level.
package uie_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [3:0] UIE_OFS_MASK = 4'h0;
    localparam logic [3:0] UIE_OFS_FIFO_CTRL = 4'h4;
    localparam logic [3:0] UIE_OFS_IDENT = 4'h8;
    localparam logic [3:0] UIE_OFS_LINE = 4'hC;
    localparam logic [1:0] UIE_OFS_MODEM_HI = 2'h1;
    // ==========================================
    // Reset values
    localparam logic [3:0] UIE_MASK_RST = 4'h0;
    localparam logic [7:0] UIE_FCR_RST = 8'h00;
    // ==========================================
    // Field positions
    localparam int UIE_IE_RX = 0;
    localparam int UIE_IE_TX = 1;
    localparam int UIE_IE_LINE = 2;
    localparam int UIE_IE_MODEM = 3;
    localparam int UIE_FCR_EN = 0;
    localparam int UIE_FCR_TRIG_LO = 6;
    // ==========================================
    // Identification codes, bit 0 is "none pending"
    localparam logic [3:0] UIE_ID_NONE = 4'h1;
    localparam logic [3:0] UIE_ID_LINE = 4'h6;
    localparam logic [3:0] UIE_ID_RX = 4'h4;
    localparam logic [3:0] UIE_ID_TX = 4'h2;
    localparam logic [3:0] UIE_ID_MODEM = 4'h0;
    // Receive trigger levels selected by the two top control bits
    localparam logic [4:0] UIE_TRIG_L0 = 5'h01;
    localparam logic [4:0] UIE_TRIG_L1 = 5'h04;
    localparam logic [4:0] UIE_TRIG_L2 = 5'h08;
    localparam logic [4:0] UIE_TRIG_L3 = 5'h0E;
    // Bus answer states
    typedef enum logic [1:0] {UIE_IDLE = 2'b00, UIE_ACK = 2'b01} uie_bus_t;
endpackage

// [hw/uie_src_if.sv]
`timescale 1ns/100ps
// Source conditions passed between the evaluator and the top
interface uie_src_if;
    logic [3:0] enables;
    logic fifo_mode;
    logic [4:0] trig_level;
    logic [4:0] rx_count;
    logic rx_hold_full;
    logic [3:0] modem_change;
    logic [3:0] line_err;
    logic tx_empty_evt;
    logic tx_clear;
    logic [3:0] ident;
    logic irq_any;
    modport eval (input enables, fifo_mode, trig_level, rx_count, rx_hold_full,
        modem_change, line_err, tx_empty_evt, tx_clear, output ident, irq_any);
    modport top (output enables, fifo_mode, trig_level, rx_count, rx_hold_full,
        modem_change, line_err, tx_empty_evt, tx_clear, input ident, irq_any);
endinterface

// [hw/uie_eval.sv]
`timescale 1ns/100ps
// Source gating, transmit-empty latch and priority encoding
module uie_eval
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Source conditions
    uie_src_if.eval s
);
    typedef struct packed
    {
        logic tx_pend;
    } uie_eval_st_t;
    uie_eval_st_t st_r;
    uie_eval_st_t st_nxt;
    logic rx_hit;
    logic line_hit;
    logic modem_hit;
    logic tx_hit;

    // Transmit empty latch: new empty event wins over a clear
    always_comb
    begin
        st_nxt = st_r;
        if (s.tx_clear)
            st_nxt.tx_pend = 1'b0;
        if (s.tx_empty_evt)
            st_nxt.tx_pend = 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // Enabled source terms
    always_comb
    begin
        rx_hit = s.enables[uie_pkg::UIE_IE_RX] && (s.fifo_mode
            ? (s.rx_count >= s.trig_level)
            : s.rx_hold_full);
        tx_hit = s.enables[uie_pkg::UIE_IE_TX] && st_r.tx_pend;
        line_hit = s.enables[uie_pkg::UIE_IE_LINE] && (|s.line_err);
        modem_hit = s.enables[uie_pkg::UIE_IE_MODEM] && (|s.modem_change);
    end

    // Priority: line, receive, transmit, modem
    always_comb
    begin
        if (line_hit)
            s.ident = uie_pkg::UIE_ID_LINE;
        else if (rx_hit)
            s.ident = uie_pkg::UIE_ID_RX;
        else if (tx_hit)
            s.ident = uie_pkg::UIE_ID_TX;
        else if (modem_hit)
            s.ident = uie_pkg::UIE_ID_MODEM;
        else
            s.ident = uie_pkg::UIE_ID_NONE;
        s.irq_any = rx_hit | tx_hit | line_hit | modem_hit;
    end
endmodule

// [bench/uie_chk_asserts.sv]
`timescale 1ns/100ps
// ==========================================
// Port checker
module uie_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus and status
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [4:0] rx_count,
    input wire logic rx_char_in,
    input wire logic [3:0] rx_err_flags,
    input wire logic rx_fifo_err,
    input wire logic tx_fifo_empty,
    input wire logic tx_shift_empty,
    input wire logic [3:0] modem_change,
    input wire logic irq_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_ok;
    logic req;
    logic src;
    // Read answer, request and any raw source
    assign rd_ok = avs_read && !avs_waitrequest;
    assign req = avs_read || avs_write;
    assign src = |{modem_change, rx_err_flags, rx_count, rx_char_in, tx_fifo_empty};
    a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_answer_time: assert property ($rose(req) |-> ##[1:2] !avs_waitrequest)
        else $error("no answer in time");
    a_idle_wait: assert property (!req ##1 !req |-> avs_waitrequest)
        else $error("answer without request");
    a_mask_upper: assert property (rd_ok && avs_address == 4'h0
        |-> avs_readdata[31:4] == 28'h0)
        else $error("mask upper bits set");
    a_unmapped_zero: assert property (rd_ok && avs_address[1:0] != 2'h0
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_ident_fmt: assert property (rd_ok && avs_address == 4'h8
        |-> avs_readdata[7] == avs_readdata[6] && avs_readdata[5:4] == 2'h0)
        else $error("ident format wrong");
    a_line_bits: assert property (rd_ok && avs_address == 4'hC
        && $stable(rx_err_flags) && $stable(tx_fifo_empty)
        |-> avs_readdata[7:1] == {rx_fifo_err, tx_fifo_empty && tx_shift_empty,
        tx_fifo_empty, rx_err_flags})
        else $error("line state bits wrong");
    a_data_ready: assert property (rd_ok && avs_address == 4'hC
        && rx_count != 5'h0 && $stable(rx_count) |-> avs_readdata[0])
        else $error("data ready low with data");
    a_irq_cause: assert property (!irq_n |-> src || $past(src) || $past(src, 2))
        else $error("request without source");
    c_irq: cover property ($fell(irq_n));
    c_ident: cover property (rd_ok && avs_address == 4'h8);
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind uie_top uie_chk u_chk (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_count(rx_count), .rx_char_in(rx_char_in), .rx_err_flags(rx_err_flags),
    .rx_fifo_err(rx_fifo_err), .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
    .modem_change(modem_change), .irq_n(irq_n));

// [bench/uie_host.sv]
`timescale 1ns/100ps
// ==========================================
// Host model, bus master
module uie_host
(
    // Clock
    input wire logic clk,
    // Bus
    output logic [3:0] address = 4'h0,
    output logic read = 1'b0,
    output logic write = 1'b0,
    output logic [31:0] writedata = 32'h0,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    // One cycle, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        @(posedge clk);
        while (waitrequest)
            @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/100ps
// ==========================================
// Self-checking bench
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] adr;
    logic rd_s;
    logic wr_s;
    logic [31:0] wd;
    logic [31:0] rdat;
    logic wreq;
    logic [4:0] cnt = 5'h0;
    logic chr = 1'b0;
    logic [3:0] err = 4'h0;
    logic ferr = 1'b0;
    logic tfe = 1'b1;
    logic tse = 1'b1;
    logic [3:0] mdm = 4'h0;
    logic irq_n;
    logic [31:0] q;
    logic [31:0] seed = 32'h46A3;
    logic [3:0] ids [4] = '{4'h4, 4'h2, 4'h6, 4'h0};
    logic [4:0] trg [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
    int n_mismatch = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    uie_top u_dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .rx_count(cnt),
        .rx_char_in(chr), .rx_err_flags(err), .rx_fifo_err(ferr), .tx_fifo_empty(tfe),
        .tx_shift_empty(tse), .modem_change(mdm), .irq_n(irq_n));
    uie_host u_host (.clk(clk), .address(adr), .read(rd_s), .write(wr_s), .writedata(wd),
        .readdata(rdat), .waitrequest(wreq));
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic irq(input logic e);
        repeat (4) @(posedge clk);
        chk({31'h0, irq_n}, {31'h0, e});
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a);
        u_host.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {1'b0, v[31:1]} ^ (v[0] ? 32'hA3000001 : 32'h0);
    endfunction
    // Expected line state image from the driven status inputs
    function automatic logic [31:0] line_exp();
        line_exp = {24'h0, ferr, tfe & tse, tfe, err, cnt != 5'h0};
    endfunction
    // Watchdog
    initial
    begin
        #100000;
        n_mismatch++;
        results;
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0);
        chk(q, 32'h0);
        wr(4'h0, 32'hFF);
        rd(4'h0);
        chk(q, 32'h0F);
        rd(4'h2);
        chk(q, 32'h0);
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h01);
        mdm <= 4'hF;
        err <= 4'hF;
        cnt <= 5'h10;
        irq(1'b1);
        rd(4'h8);
        chk(q, 32'hC1);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h0, 32'h1 << i);
            cnt <= (i == 0) ? 5'h01 : 5'h00;
            tfe <= (i == 1);
            err <= (i == 2) ? 4'h2 : 4'h0;
            mdm <= (i == 3) ? 4'h4 : 4'h0;
            irq(1'b0);
            rd(4'h8);
            chk(q, {24'h0, 4'hC, ids[i]});
            irq(i == 1);
            {cnt, tfe, err, mdm} <= 14'h0;
            irq(1'b1);
        end
        wr(4'h0, 32'h1);
        for (int t = 0; t < 4; t++)
        begin
            wr(4'h4, {24'h0, t[1:0], 6'h01});
            cnt <= trg[t] - 5'h01;
            irq(1'b1);
            cnt <= trg[t];
            irq(1'b0);
            rd(4'h8);
            chk(q, 32'hC4);
        end
        wr(4'h4, 32'h0);
        cnt <= 5'h0;
        irq(1'b1);
        cnt <= 5'h01;
        chr <= 1'b1;
        @(posedge clk);
        chr <= 1'b0;
        irq(1'b0);
        rd(4'hC);
        chk({31'h0, q[0]}, 32'h1);
        cnt <= 5'h0;
        irq(1'b1);
        wr(4'h0, 32'h0);
        for (int k = 0; k < 12; k++)
        begin
            seed = lfsr(seed);
            {ferr, tse, tfe, err, cnt} <= seed[11:0];
            repeat (3) @(posedge clk);
            rd(4'hC);
            chk(q, line_exp());
        end
        results;
    end
endmodule
